// ===== verilog/plcap_top.v
// pci local-side address capture and data path with a receive fifo
// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
// Overview of operation
// RQ1 - lower start address latched one clock after frame asserts, held until next
// RQ2 - upper address latched two clocks after frame on dual address cycle only
// RQ3 - local byte enables mark meaningful lanes during target reads and writes
// RQ4 - bus command latched in address phase, shown for the current cycle
// RQ5 - application drives address and data on the local input bus
// RQ6 - lower received dword delivered on lower local data output
// RQ7 - upper received dword delivered on upper local data output
// RQ8 - local master supplies command and active-low byte enables
// RQ9 - local interface runs on the single system clock
// RQ10 - master holds frame low for the cycle; start is the reference
// RQ11 - reset clears captured address, command and byte enables
`timescale 1ns/100ps
`include "plcap_defs.vh"

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module plcap_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_wdata,
  input  wire             i_wvalid,
  output wire             o_wready,
  output wire [WIDTH-1:0] o_rdata,
  output wire             o_rvalid,
  input  wire             i_rready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  reg [AW:0]      count;
  wire            do_w;
  wire            do_r;
  // depth is a power of two, so full is the top bit of the count alone
  localparam [AW:0] FULL_COUNT = {1'b1, {AW{1'b0}}};
  assign o_wready = (count != FULL_COUNT);
  assign o_rvalid = (count != {(AW+1){1'b0}});
  assign o_rdata  = mem[rptr];
  assign do_w     = i_wvalid & o_wready;
  assign do_r     = o_rvalid & i_rready;
  always @(posedge i_clk) begin
    if (do_w) begin
      mem[wptr] <= i_wdata;
    end
  end
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_w) begin
        wptr <= wptr + 1'b1;
      end
      if (do_r) begin
        rptr <= rptr + 1'b1;
      end
      case ({do_w, do_r})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule // plcap_fifo

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module plcap_top (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_frame_n,
  input  wire [63:0] i_pci_ad,
  input  wire [3:0]  i_pci_cbe_n,
  input  wire [3:0]  i_pci_cbe_hi_n,
  input  wire        i_bar64_hit,
  input  wire        i_rx_valid,
  input  wire [63:0] i_rx_data,
  output wire        o_rx_ready,
  input  wire        i_tgt_phase,
  input  wire        i_rx_drain,
  input  wire [63:0] i_local_ad,
  input  wire [3:0]  i_initiator_cmd_byte_enable_input,
  output reg  [31:0] o_target_start_address_output,
  output reg  [31:0] o_target_start_address_output_hi,
  output reg  [3:0]  o_target_bus_command_output,
  output reg  [3:0]  o_target_byte_enable_output,
  output reg  [63:0] o_local_data,
  output reg         o_local_data_valid,
  output reg  [63:0] o_pci_ad_drive,
  output reg  [3:0]  o_pci_cbe_drive_n
);

  // ----------------------------------------------------------------
  // local state
  // ----------------------------------------------------------------
  reg         frame_d;
  reg         addr2;
  reg         hit64;
  reg         in_data;
  reg         rx_ready_q;
  reg  [5:0]  rx_cnt;
  reg  [5:0]  next_rx_cnt;
  reg         next_rx_ready;
  wire        frame_start;
  wire        is_dac;
  wire        rx_push;
  wire [63:0] f_data;
  wire        f_valid;
  wire        f_pop;
  wire        f_wready;

  // ----------------------------------------------------------------
  // cycle start detection
  // ----------------------------------------------------------------

  // start of cycle is the falling edge of frame
  assign frame_start = frame_d & ~i_frame_n; // RQ10
  // dual address command in the first address phase
  assign is_dac      = (i_pci_cbe_n == `PLCAP_CMD_DAC);

  // resets to the idle level of frame, so no false start follows reset
  always @(posedge i_clk) begin // RQ9
    if (!i_rst_n) begin
      frame_d <= 1'b1;
    end else begin
      frame_d <= i_frame_n;
    end
  end

  // ----------------------------------------------------------------
  // address phase tracking
  // ----------------------------------------------------------------

  // addr2 marks the second address phase of a dual address cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr2 <= 1'b0;
    end else begin
      addr2 <= frame_start & is_dac;
    end
  end

  // upper address is only kept when a 64-bit window claims the cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      hit64 <= 1'b0;
    end else begin
      hit64 <= frame_start & is_dac & i_bar64_hit; // RQ2
    end
  end

  // data phases follow the address phases; the last one has frame high
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_data <= 1'b0;
    end else if (frame_start) begin
      in_data <= ~is_dac;
    end else if (addr2) begin
      in_data <= 1'b1;
    end else if (i_frame_n) begin
      in_data <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // lower start address
  // ----------------------------------------------------------------

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_target_start_address_output <= `PLCAP_RST_ADDR; // RQ11
    end else if (frame_start) begin
      o_target_start_address_output <= i_pci_ad[31:0]; // RQ1
    end
  end

  // ----------------------------------------------------------------
  // upper start address
  // ----------------------------------------------------------------

  // single address cycles leave the old upper half in place
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_target_start_address_output_hi <= `PLCAP_RST_ADDR; // RQ11
    end else if (hit64) begin
      o_target_start_address_output_hi <= i_pci_ad[31:0]; // RQ2
    end
  end

  // ----------------------------------------------------------------
  // bus command
  // ----------------------------------------------------------------

  // a dual address cycle carries the real command in its second phase
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_target_bus_command_output <= `PLCAP_RST_CBE; // RQ11
    end else if (frame_start) begin
      o_target_bus_command_output <= i_pci_cbe_n; // RQ4
    end else if (addr2) begin
      o_target_bus_command_output <= i_pci_cbe_n; // RQ4
    end
  end

  // ----------------------------------------------------------------
  // byte enables
  // ----------------------------------------------------------------

  // only the lower lane group is kept; the upper enables are not shown
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_target_byte_enable_output <= `PLCAP_RST_CBE; // RQ11
    end else if (in_data & i_tgt_phase) begin
      o_target_byte_enable_output <= i_pci_cbe_n; // RQ3
    end
  end

  // ----------------------------------------------------------------
  // receive credit count
  // ----------------------------------------------------------------

  // ready is registered, so a shadow count predicts the fill level
  assign rx_push    = i_rx_valid & rx_ready_q & f_wready;
  assign f_pop      = f_valid & i_rx_drain;
  assign o_rx_ready = rx_ready_q;

  always @* begin
    next_rx_cnt = rx_cnt;
    case ({rx_push, f_pop})
      2'b10: begin
        next_rx_cnt = rx_cnt + 6'h01;
      end
      2'b01: begin
        next_rx_cnt = rx_cnt - 6'h01;
      end
      default: begin
        next_rx_cnt = rx_cnt;
      end
    endcase
    next_rx_ready = (next_rx_cnt != `PLCAP_FIFO_FULL);
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_cnt     <= 6'h00;
      rx_ready_q <= 1'b0;
    end else begin
      rx_cnt     <= next_rx_cnt;
      rx_ready_q <= next_rx_ready;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------

  // a stalled consumer fills the fifo, which then back-pressures the pci side
  plcap_fifo #(
    .WIDTH (`PLCAP_QW),
    .DEPTH (`PLCAP_FIFO_DEPTH),
    .AW    (`PLCAP_FIFO_AW)
  ) u_rx_fifo (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_wdata  (i_rx_data),
    .i_wvalid (rx_push),
    .o_wready (f_wready),
    .o_rdata  (f_data),
    .o_rvalid (f_valid),
    .i_rready (i_rx_drain)
  );

  // ----------------------------------------------------------------
  // local data output
  // ----------------------------------------------------------------

  // valid stands for exactly one cycle per word taken from the fifo
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_local_data_valid <= 1'b0;
    end else begin
      o_local_data_valid <= f_pop;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_local_data <= 64'h0000000000000000;
    end else if (f_pop) begin
      o_local_data[31:0]  <= f_data[31:0]; // RQ6
      o_local_data[63:32] <= f_data[63:32]; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // master drive path
  // ----------------------------------------------------------------

  // one register stage toward the pad; enables idle inactive (high)
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pci_ad_drive    <= 64'h0000000000000000;
      o_pci_cbe_drive_n <= 4'hf;
    end else begin
      o_pci_ad_drive    <= i_local_ad;
      o_pci_cbe_drive_n <= i_initiator_cmd_byte_enable_input;
    end
  end

endmodule // plcap_top

// ===== inc/plcap_defs.vh
// constants for the pci local-side capture block
`ifndef PLCAP_DEFS_VH
`define PLCAP_DEFS_VH
`define PLCAP_DW          32
`define PLCAP_QW          64
`define PLCAP_CBW         4
`define PLCAP_FIFO_DEPTH  32
`define PLCAP_FIFO_AW     5
`define PLCAP_FIFO_FULL   6'h20
`define PLCAP_CMD_DAC     4'hd
`define PLCAP_RST_ADDR    32'h00000000
`define PLCAP_RST_CBE     4'h0
`endif

// ===== bench/plcap_top_properties.sv
// concurrent checks on the capture block ports
`timescale 1ns/100ps
module plcap_props(input wire i_clk,i_rst_n,i_frame_n,i_bar64_hit,o_local_data_valid,
  input wire [63:0] i_pci_ad,input wire [3:0] i_pci_cbe_n,o_target_bus_command_output,
  o_target_byte_enable_output,input wire [31:0] o_target_start_address_output,
  o_target_start_address_output_hi);
  wire [31:0] a = o_target_start_address_output;
  wire [31:0] h = o_target_start_address_output_hi;
  wire [3:0]  c = o_target_bus_command_output;
  wire [3:0]  b = o_target_byte_enable_output;
  wire dac = i_pci_cbe_n == 4'hd;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_LO_CAP: assert property($fell(i_frame_n) |=> a == $past(i_pci_ad[31:0])) else $error("lo addr");
  AST_LO_HOLD: assert property(!$fell(i_frame_n) |=> $stable(a)) else $error("lo hold");
  AST_HI_CAP: assert property($fell(i_frame_n) && dac && i_bar64_hit |-> ##1 1 ##1
    h == $past(i_pci_ad[31:0])) else $error("hi addr");
  AST_HI_HOLD: assert property($fell(i_frame_n) && !dac |-> ##2 $stable(h)) else $error("hi hold");
  AST_CMD: assert property($fell(i_frame_n) && !dac |=> c == $past(i_pci_cbe_n)) else $error("cmd");
  AST_BE: assert property($fell(i_frame_n) && !dac ##1 1 |=> b == $past(i_pci_cbe_n)) else $error("be");
  AST_RST: assert property(disable iff (1'b0) !i_rst_n |=> a == 0 && c == 0 && b == 0) else $error("rst");
  AST_RST_HI: assert property(disable iff (1'b0) !i_rst_n |=> h == 0) else $error("rst hi");
  C_SAC: cover property($fell(i_frame_n) && !dac);
  C_DAC: cover property($fell(i_frame_n) && dac && i_bar64_hit);
  C_DATA: cover property(o_local_data_valid);
endmodule // plcap_props
bind plcap_top plcap_props u_props(.*);

// ===== bench/plcap_app.sv
// local application model: drives local inputs and takes received data
`timescale 1ns/100ps
module plcap_app(input wire i_clk,input wire i_go,output reg o_drain,
  output reg [63:0] o_ad,output reg [3:0] o_cbe_n);
  // idle master: all byte enables off, distinct address pattern
  initial o_ad = 64'h0123_4567_89ab_cdef;
  initial o_cbe_n = 4'hf;
  // stalls the receive path until told to take data
  always @(negedge i_clk) o_drain <= i_go;
endmodule // plcap_app

// ===== bench/pci_local_side_capture_test.sv
// self-checking bench for the local-side capture block
`timescale 1ns/100ps
module pci_local_side_capture_test;
  reg clk=0,rst_n=0,fr_n=1,hit=0,rxv=0,go=0,r; reg [63:0] ad=0,rxd=0; reg [3:0] cbe=4'hf;
  reg [31:0] eh=0; wire [31:0] lo,hi; wire [3:0] cmd,be,lcbe; wire [63:0] ld,lad; wire rdy,lv,drn;
  integer bad_count=0,comparisons=0,i,n; wire [63:0] pad; wire [3:0] pcb;
  initial forever #2.5 clk=~clk;
  plcap_app app(.i_clk(clk),.i_go(go),.o_drain(drn),.o_ad(lad),.o_cbe_n(lcbe));
  plcap_top uut(.i_clk(clk),.i_rst_n(rst_n),.i_frame_n(fr_n),.i_pci_ad(ad),.i_pci_cbe_n(cbe),
    .i_pci_cbe_hi_n(4'h0),.i_bar64_hit(hit),.i_rx_valid(rxv),.i_rx_data(rxd),.o_rx_ready(rdy),
    .i_tgt_phase(1'b1),.i_rx_drain(drn),.i_local_ad(lad),.i_initiator_cmd_byte_enable_input(lcbe),
    .o_target_start_address_output(lo),.o_target_start_address_output_hi(hi),
    .o_target_bus_command_output(cmd),.o_target_byte_enable_output(be),.o_local_data(ld),
    .o_local_data_valid(lv),.o_pci_ad_drive(pad),.o_pci_cbe_drive_n(pcb));
  task chk(input string s,input [63:0] g,e); begin
    comparisons=comparisons+1;
    if (g!==e) begin bad_count=bad_count+1; $display("CHECK FAILED %s exp %h got %h",s,e,g); end
  end endtask
  task wrap_up; begin
    $display("checks %0d mismatches %0d",comparisons,bad_count);
    if (bad_count==0 && comparisons>0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  // address phase, optional dual address phase, two data phases (frame low, then frame high)
  task t_addr(input [3:0] c,input [31:0] l,h,input d); begin
    @(negedge clk); fr_n=0; ad={h,l}; cbe=c; hit=1;
    @(negedge clk); ad={h,h}; cbe=d ? 4'h6 : 4'h3;
    if (d) begin @(negedge clk); cbe=4'h3; eh=h; end
    @(negedge clk); fr_n=1; repeat(2) @(negedge clk);
    chk("lo",lo,l);
    chk("hi",hi,eh);
    chk("be",be,4'h3);
    if (!d) chk("cmd",cmd,c);
    else chk("dcmd",cmd,4'h6);
    $display("addr test done");
  end endtask
  // fill while the application stalls, then drain in order
  task t_fifo; begin
    n=0; for (i=0;i<40;i=i+1) begin @(negedge clk); rxd={~n,n}; rxv=1; #1 r=rdy; @(posedge clk);
    if (r) n=n+1; end
    @(negedge clk); rxv=0; go=1; chk("fill",n,32);
    n=0; for (i=0;i<200 && n<32;i=i+1) begin @(negedge clk);
    if (lv) begin chk("data",ld,{~n,n}); n=n+1; end end
    chk("drained",n,32); $display("fifo test done");
  end endtask
  initial begin #20000; bad_count=bad_count+1; wrap_up; end
  initial begin
    repeat(4) @(negedge clk); rst_n=1;
    chk("rst",{hi,lo},64'h0);
    chk("rst cb",{cmd,be},8'h0);
    t_addr(4'h6,32'h1357_9bdf,32'h0,0); t_addr(4'hd,32'h2468_ace0,32'h8000_0001,1);
    t_addr(4'h7,32'h0f0f_0f0f,32'h0,0);
    chk("pad",pad,64'h0123_4567_89ab_cdef);
    chk("pcbe",pcb,4'hf);
    t_fifo; wrap_up;
  end
endmodule // pci_local_side_capture_test
